//--- core/pifeb_bank.sv
// Peripheral interrupt flag and enable register bank with Avalon-MM slave.
// Assumes event inputs are one-cycle pulses synchronous to clk, the serial
// buffer states are levels from the serial block, and per-source priority
// bits come from a priority register bank outside this module.
//
// Behaviour
// - Flags set on their source event regardless of any enable bit.
// - ADC done sets flag1 bit 6; stays until software writes zero.
// - Flag1 bit 5 read-only, mirrors receive buffer full.
// - Flag1 bit 4 read-only, mirrors transmit buffer empty.
// - Flag1 bits 3..1 set when comparator 2..0 output changes.
// - Timer 1 overflow sets flag1 bit 0 until software clears it.
// - Unimplemented flag and enable bits read zero and ignore writes.
// - Oscillator failure sets flag2 bit 7; software clears it.
// - Nonvolatile write completion sets flag2 bit 4 until cleared.
// - Low-voltage detection sets flag2 bit 2.
// - PWM period match, after postscaler, sets flag3 bit 4.
// - Enable1 bits 6..0 enable the matching flag1 sources.
// - Without priority levels, peripheral requests need the peripheral enable.
// - Enable2 bits 7, 4, 2 enable oscillator, write, low-voltage sources.
// - Enable3 bit 4 enables the PWM time-base source.
// - With priority levels, peripheral enable gates all low-priority requests.
// - Per-source priority bits, outside, matter only with priority levels.
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pifeb_bank
    import pifeb_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [PIFEB_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [PIFEB_DATA_W-1:0] writedata,
    output logic [PIFEB_DATA_W-1:0] readdata,
    output logic waitrequest,
    // Peripheral sources
    input wire logic adc_done_evt,
    input wire logic rx_buffer_full,
    input wire logic tx_buffer_empty,
    input wire logic [2:0] comparator_out,
    input wire logic timer1_overflow_evt,
    input wire logic osc_fail_evt,
    input wire logic nv_write_done_evt,
    input wire logic low_voltage_evt,
    input wire logic pwm_period_match_evt,
    input wire logic [PIFEB_PS_W-1:0] pwm_postscale,
    // Priority bits held outside, one per flag position
    input wire logic [PIFEB_REG_W-1:0] priority_1,
    input wire logic [PIFEB_REG_W-1:0] priority_2,
    input wire logic [PIFEB_REG_W-1:0] priority_3,
    // Toward the core
    output logic periph_irq_req,
    output logic irq_high_req,
    output logic irq_low_req
);

    function automatic logic hit(input logic [PIFEB_ADDR_W-1:0] a,
                                 input logic [PIFEB_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic [PIFEB_REG_W-1:0] flags_1_q;
    logic [PIFEB_REG_W-1:0] flags_2_q;
    logic [PIFEB_REG_W-1:0] flags_3_q;
    logic [PIFEB_REG_W-1:0] enables_1_q;
    logic [PIFEB_REG_W-1:0] enables_2_q;
    logic [PIFEB_REG_W-1:0] enables_3_q;
    logic [PIFEB_REG_W-1:0] core_ctrl_q;
    logic [2:0] cmp_prev_q;
    logic [PIFEB_PS_W-1:0] ps_cnt_q;
    logic ack_q;
    logic [PIFEB_DATA_W-1:0] readdata_q;
    logic periph_irq_req_q;
    logic irq_high_req_q;
    logic irq_low_req_q;

    logic [PIFEB_REG_W-1:0] flags_1_view;
    logic [PIFEB_REG_W-1:0] set_1;
    logic [PIFEB_REG_W-1:0] set_2;
    logic [PIFEB_REG_W-1:0] set_3;
    logic [PIFEB_REG_W-1:0] pend_1;
    logic [PIFEB_REG_W-1:0] pend_2;
    logic [PIFEB_REG_W-1:0] pend_3;
    logic [PIFEB_REG_W-1:0] rd_byte;
    logic [PIFEB_REG_W-1:0] wbyte;
    logic wr_go;
    logic pwm_fire;
    logic any_pend;
    logic any_high;
    logic any_low;
    logic global_irq_enable;
    logic peripheral_global_enable;
    logic priority_levels_enable;

    // Bus handshake: one wait state, then the answer; write lands on that edge
    assign waitrequest = (read | write) & ~ack_q;
    assign wr_go = write & ack_q & byteenable[0];
    assign wbyte = writedata[PIFEB_REG_W-1:0];
    assign readdata = readdata_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read | write) & ~ack_q;
        end
    end

    // Serial buffer flags are live views of the serial block
    always_comb begin
        flags_1_view = flags_1_q & PIFEB_RW_FLAGS_1;
        flags_1_view[PIFEB_BIT_RX] = rx_buffer_full;
        flags_1_view[PIFEB_BIT_TX] = tx_buffer_empty;
    end

    always_comb begin
        rd_byte = PIFEB_REG_RESET;
        if (hit(address, PIFEB_OFS_FLAGS_1)) begin
            rd_byte = flags_1_view;
        end else if (hit(address, PIFEB_OFS_FLAGS_2)) begin
            rd_byte = flags_2_q & PIFEB_MASK_2;
        end else if (hit(address, PIFEB_OFS_FLAGS_3)) begin
            rd_byte = flags_3_q & PIFEB_MASK_3;
        end else if (hit(address, PIFEB_OFS_ENABLES_1)) begin
            rd_byte = enables_1_q & PIFEB_MASK_1;
        end else if (hit(address, PIFEB_OFS_ENABLES_2)) begin
            rd_byte = enables_2_q & PIFEB_MASK_2;
        end else if (hit(address, PIFEB_OFS_ENABLES_3)) begin
            rd_byte = enables_3_q & PIFEB_MASK_3;
        end else if (hit(address, PIFEB_OFS_CORE_CTRL)) begin
            rd_byte = core_ctrl_q & PIFEB_MASK_CTRL;
        end
    end

    // Read data captured in the wait state so it is stable when sampled
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readdata_q <= '0;
        end else if (read & ~ack_q) begin
            readdata_q <= {{(PIFEB_DATA_W-PIFEB_REG_W){1'b0}}, rd_byte};
        end
    end

    // Comparator change detect; the previous value is the last one seen
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmp_prev_q <= 3'h0;
        end else begin
            cmp_prev_q <= comparator_out;
        end
    end

    // PWM postscaler: flag on every (pwm_postscale + 1)th match
    assign pwm_fire = pwm_period_match_evt & (ps_cnt_q >= pwm_postscale);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ps_cnt_q <= '0;
        end else if (pwm_fire) begin
            ps_cnt_q <= '0;
        end else if (pwm_period_match_evt) begin
            ps_cnt_q <= ps_cnt_q + 1'b1;
        end
    end

    always_comb begin
        set_1 = PIFEB_REG_RESET;
        set_1[PIFEB_BIT_ADC] = adc_done_evt;
        set_1[PIFEB_BIT_CMP_HI:PIFEB_BIT_CMP_LO] = comparator_out ^ cmp_prev_q;
        set_1[PIFEB_BIT_TMR1] = timer1_overflow_evt;
        set_2 = PIFEB_REG_RESET;
        set_2[PIFEB_BIT_OSCF] = osc_fail_evt;
        set_2[PIFEB_BIT_NVW] = nv_write_done_evt;
        set_2[PIFEB_BIT_LVD] = low_voltage_evt;
        set_3 = PIFEB_REG_RESET;
        set_3[PIFEB_BIT_PWM] = pwm_fire;
    end

    // Flags: a hardware set wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_1_q <= PIFEB_REG_RESET;
            flags_2_q <= PIFEB_REG_RESET;
            flags_3_q <= PIFEB_REG_RESET;
        end else begin
            if (wr_go && hit(address, PIFEB_OFS_FLAGS_1)) begin
                flags_1_q <= (wbyte | set_1) & PIFEB_RW_FLAGS_1;
            end else begin
                flags_1_q <= (flags_1_q | set_1) & PIFEB_RW_FLAGS_1;
            end
            if (wr_go && hit(address, PIFEB_OFS_FLAGS_2)) begin
                flags_2_q <= (wbyte | set_2) & PIFEB_MASK_2;
            end else begin
                flags_2_q <= (flags_2_q | set_2) & PIFEB_MASK_2;
            end
            if (wr_go && hit(address, PIFEB_OFS_FLAGS_3)) begin
                flags_3_q <= (wbyte | set_3) & PIFEB_MASK_3;
            end else begin
                flags_3_q <= (flags_3_q | set_3) & PIFEB_MASK_3;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enables_1_q <= PIFEB_REG_RESET;
            enables_2_q <= PIFEB_REG_RESET;
            enables_3_q <= PIFEB_REG_RESET;
            core_ctrl_q <= PIFEB_REG_RESET;
        end else if (wr_go) begin
            if (hit(address, PIFEB_OFS_ENABLES_1)) begin
                enables_1_q <= wbyte & PIFEB_MASK_1;
            end
            if (hit(address, PIFEB_OFS_ENABLES_2)) begin
                enables_2_q <= wbyte & PIFEB_MASK_2;
            end
            if (hit(address, PIFEB_OFS_ENABLES_3)) begin
                enables_3_q <= wbyte & PIFEB_MASK_3;
            end
            if (hit(address, PIFEB_OFS_CORE_CTRL)) begin
                core_ctrl_q <= wbyte & PIFEB_MASK_CTRL;
            end
        end
    end

    // Request combining toward the core
    assign pend_1 = flags_1_view & enables_1_q;
    assign pend_2 = flags_2_q & enables_2_q;
    assign pend_3 = flags_3_q & enables_3_q;
    assign any_pend = |{pend_1, pend_2, pend_3};
    // Priority bits only shape routing when levels are on
    assign any_high = |{pend_1 & priority_1, pend_2 & priority_2, pend_3 & priority_3};
    assign any_low = |{pend_1 & ~priority_1, pend_2 & ~priority_2, pend_3 & ~priority_3};
    assign global_irq_enable = core_ctrl_q[PIFEB_BIT_GIE];
    assign peripheral_global_enable = core_ctrl_q[PIFEB_BIT_PERIPHERAL_GLOBAL_ENABLE];
    assign priority_levels_enable = core_ctrl_q[PIFEB_BIT_PRIORITY_LEVELS_ENABLE];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            periph_irq_req_q <= 1'b0;
            irq_high_req_q <= 1'b0;
            irq_low_req_q <= 1'b0;
        end else begin
            periph_irq_req_q <= any_pend;
            if (!priority_levels_enable) begin
                irq_high_req_q <= global_irq_enable & peripheral_global_enable & any_pend;
                irq_low_req_q <= 1'b0;
            end else begin
                irq_high_req_q <= global_irq_enable & any_high;
                irq_low_req_q <= global_irq_enable & peripheral_global_enable & any_low;
            end
        end
    end

    assign periph_irq_req = periph_irq_req_q;
    assign irq_high_req = irq_high_req_q;
    assign irq_low_req = irq_low_req_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_adc_flag_sets: assert property (
        adc_done_evt |=> flags_1_q[PIFEB_BIT_ADC])
        else $error("adc flag not set after event");

    a_adc_flag_holds: assert property (
        flags_1_q[PIFEB_BIT_ADC] && !(wr_go && hit(address, PIFEB_OFS_FLAGS_1))
        |=> flags_1_q[PIFEB_BIT_ADC])
        else $error("adc flag dropped without a write");

    a_set_beats_clear: assert property (
        timer1_overflow_evt && wr_go && hit(address, PIFEB_OFS_FLAGS_1)
        && !wbyte[PIFEB_BIT_TMR1] |=> flags_1_q[PIFEB_BIT_TMR1])
        else $error("timer flag lost to a same-cycle clear");

    // Checked through the bus so a broken read path cannot hide a bad mirror
    a_rx_flag_mirror: assert property (
        read && !waitrequest && hit(address, PIFEB_OFS_FLAGS_1)
        |-> readdata[PIFEB_BIT_RX] == $past(rx_buffer_full))
        else $error("rx flag read back does not mirror buffer state");

    a_tx_flag_mirror: assert property (
        read && !waitrequest && hit(address, PIFEB_OFS_FLAGS_1)
        |-> readdata[PIFEB_BIT_TX] == $past(tx_buffer_empty))
        else $error("tx flag read back does not mirror buffer state");

    a_rx_not_written: assert property (
        flags_1_q[PIFEB_BIT_RX] == 1'b0 && flags_1_q[PIFEB_BIT_TX] == 1'b0)
        else $error("read-only serial flag bit stored");

    a_cmp_change: assert property (
        comparator_out != $past(comparator_out)
        |=> (flags_1_q[PIFEB_BIT_CMP_HI:PIFEB_BIT_CMP_LO]
             & $past(comparator_out ^ cmp_prev_q)) == $past(comparator_out ^ cmp_prev_q))
        else $error("comparator change did not set its flag");

    a_unimpl_zero: assert property (
        (flags_2_q & ~PIFEB_MASK_2) == 8'h00 && (flags_3_q & ~PIFEB_MASK_3) == 8'h00
        && (enables_1_q & ~PIFEB_MASK_1) == 8'h00 && flags_1_q[7] == 1'b0)
        else $error("unimplemented bit holds a one");

    a_timer_flag_sets: assert property (
        timer1_overflow_evt |=> flags_1_q[PIFEB_BIT_TMR1])
        else $error("timer flag not set after overflow");

    a_osc_flag_sets: assert property (
        osc_fail_evt |=> flags_2_q[PIFEB_BIT_OSCF])
        else $error("oscillator fail flag not set");

    a_nvw_lvd_set: assert property (
        nv_write_done_evt && low_voltage_evt
        |=> flags_2_q[PIFEB_BIT_NVW] && flags_2_q[PIFEB_BIT_LVD])
        else $error("write or low-voltage flag not set");

    a_pwm_postscale: assert property (
        pwm_period_match_evt && ps_cnt_q < pwm_postscale && !flags_3_q[PIFEB_BIT_PWM]
        && !(wr_go && hit(address, PIFEB_OFS_FLAGS_3))
        |=> !flags_3_q[PIFEB_BIT_PWM] && ps_cnt_q == $past(ps_cnt_q) + 1'b1)
        else $error("pwm flag set before postscale count");

    a_pwm_flag_sets: assert property (
        pwm_fire |=> flags_3_q[PIFEB_BIT_PWM])
        else $error("pwm flag not set after postscaled match");

    a_req_follows: assert property (
        any_pend |=> periph_irq_req)
        else $error("pending source not presented to core");

    a_no_request: assert property (
        !any_pend |=> !periph_irq_req)
        else $error("request raised with nothing pending");

    a_enable1_write: assert property (
        wr_go && hit(address, PIFEB_OFS_ENABLES_1)
        |=> enables_1_q == ($past(wbyte) & PIFEB_MASK_1))
        else $error("first enable register write not taken");

    a_enable2_write: assert property (
        wr_go && hit(address, PIFEB_OFS_ENABLES_2)
        |=> enables_2_q == ($past(wbyte) & PIFEB_MASK_2))
        else $error("second enable register write not taken");

    a_enable3_write: assert property (
        wr_go && hit(address, PIFEB_OFS_ENABLES_3)
        |=> enables_3_q == ($past(wbyte) & PIFEB_MASK_3))
        else $error("third enable register write not taken");

    // Reset itself is the antecedent, so the default disable is overridden
    a_reset_clears: assert property (
        disable iff (1'b0)
        sys_rst |=> flags_1_q == PIFEB_REG_RESET && flags_2_q == PIFEB_REG_RESET
        && flags_3_q == PIFEB_REG_RESET && enables_1_q == PIFEB_REG_RESET
        && enables_2_q == PIFEB_REG_RESET && enables_3_q == PIFEB_REG_RESET
        && periph_irq_req == 1'b0)
        else $error("flag or enable state survived reset");

    a_legacy_gate: assert property (
        !priority_levels_enable && !peripheral_global_enable |=> !irq_high_req && !irq_low_req)
        else $error("request passed with peripheral enable off");

    a_low_gate: assert property (
        priority_levels_enable && global_irq_enable && peripheral_global_enable && any_low |=> irq_low_req)
        else $error("low priority request not raised");

    a_bus_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("slave answer took more than one wait state");

    c_flag_enabled_irq: cover property (
        adc_done_evt && enables_1_q[PIFEB_BIT_ADC] ##2 periph_irq_req);
    c_clear_flag: cover property (
        flags_2_q[PIFEB_BIT_OSCF] ##1 !flags_2_q[PIFEB_BIT_OSCF]);
    c_high_and_low: cover property (irq_high_req && irq_low_req);
    c_pwm_postscaled: cover property (pwm_fire && pwm_postscale != 4'h0);
    c_set_during_clear: cover property (
        timer1_overflow_evt && wr_go && hit(address, PIFEB_OFS_FLAGS_1));

endmodule : pifeb_bank

`default_nettype wire

//--- core/pifeb_pkg.sv
// Constants for the peripheral interrupt flag and enable register bank.
// Shared by the register bank and anything that needs its map or field layout.
package pifeb_pkg;

    localparam int PIFEB_ADDR_W = 5;
    localparam int PIFEB_DATA_W = 32;
    localparam int PIFEB_REG_W = 8;
    localparam int PIFEB_PS_W = 4;

    // Byte addresses of the word-aligned registers
    localparam logic [PIFEB_ADDR_W-1:0] PIFEB_OFS_FLAGS_1 = 5'h00;
    localparam logic [PIFEB_ADDR_W-1:0] PIFEB_OFS_FLAGS_2 = 5'h04;
    localparam logic [PIFEB_ADDR_W-1:0] PIFEB_OFS_FLAGS_3 = 5'h08;
    localparam logic [PIFEB_ADDR_W-1:0] PIFEB_OFS_ENABLES_1 = 5'h0C;
    localparam logic [PIFEB_ADDR_W-1:0] PIFEB_OFS_ENABLES_2 = 5'h10;
    localparam logic [PIFEB_ADDR_W-1:0] PIFEB_OFS_ENABLES_3 = 5'h14;
    localparam logic [PIFEB_ADDR_W-1:0] PIFEB_OFS_CORE_CTRL = 5'h18;

    // Implemented bits of each register pair
    localparam logic [PIFEB_REG_W-1:0] PIFEB_MASK_1 = 8'h7F;
    localparam logic [PIFEB_REG_W-1:0] PIFEB_MASK_2 = 8'h94;
    localparam logic [PIFEB_REG_W-1:0] PIFEB_MASK_3 = 8'h10;
    // Flag bits of the first register that software may write
    localparam logic [PIFEB_REG_W-1:0] PIFEB_RW_FLAGS_1 = 8'h4F;
    localparam logic [PIFEB_REG_W-1:0] PIFEB_REG_RESET = 8'h00;

    // Field positions
    localparam int PIFEB_BIT_ADC = 6;
    localparam int PIFEB_BIT_RX = 5;
    localparam int PIFEB_BIT_TX = 4;
    localparam int PIFEB_BIT_CMP_LO = 1;
    localparam int PIFEB_BIT_CMP_HI = 3;
    localparam int PIFEB_BIT_TMR1 = 0;
    localparam int PIFEB_BIT_OSCF = 7;
    localparam int PIFEB_BIT_NVW = 4;
    localparam int PIFEB_BIT_LVD = 2;
    localparam int PIFEB_BIT_PWM = 4;

    // Core control register layout
    localparam int PIFEB_BIT_GIE = 7;
    localparam int PIFEB_BIT_PERIPHERAL_GLOBAL_ENABLE = 6;
    localparam int PIFEB_BIT_PRIORITY_LEVELS_ENABLE = 0;
    localparam logic [PIFEB_REG_W-1:0] PIFEB_MASK_CTRL = 8'hC1;

endpackage : pifeb_pkg

//--- verification/pifeb_periph_model.sv
// Behavioural stand-in for the on-chip peripherals that feed the flag bank.
// Assumes the bench raises a bit of fire for one clock per wanted event.
`timescale 1ns/1ps
`default_nettype none

module pifeb_periph_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [5:0] fire,
    output logic adc_done_evt,
    output logic timer1_overflow_evt,
    output logic osc_fail_evt,
    output logic nv_write_done_evt,
    output logic low_voltage_evt,
    output logic pwm_period_match_evt
);
    // Registered so every event is a clean one-cycle pulse after an edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {adc_done_evt, timer1_overflow_evt, osc_fail_evt} <= 3'h0;
            {nv_write_done_evt, low_voltage_evt, pwm_period_match_evt} <= 3'h0;
        end else begin
            {adc_done_evt, timer1_overflow_evt, osc_fail_evt} <= fire[2:0];
            {nv_write_done_evt, low_voltage_evt, pwm_period_match_evt} <= fire[5:3];
        end
    end
endmodule : pifeb_periph_model

`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the peripheral flag and enable bank.
// Assumes one wait state per bus request and quiet sources while registers are read.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import pifeb_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [PIFEB_ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'h0;
    logic [PIFEB_DATA_W-1:0] writedata = '0;
    logic [PIFEB_DATA_W-1:0] readdata;
    logic waitrequest, periph_irq_req, irq_high_req, irq_low_req;
    logic [5:0] fire = 6'h00;
    logic rx_buffer_full = 1'b0;
    logic tx_buffer_empty = 1'b0;
    logic [2:0] comparator_out = 3'h0;
    logic [PIFEB_PS_W-1:0] pwm_postscale = 4'h0;
    logic [7:0] priority_1 = 8'h00, priority_2 = 8'h00, priority_3 = 8'h00;
    logic ev_adc, ev_tmr, ev_osc, ev_nv, ev_lvd, ev_pwm;
    logic [7:0] m_f1, m_f2, m_f3, m_e1, m_e2, m_e3, m_ctl;
    logic [2:0] cmp_prev;
    int pcnt;
    int failures = 0;
    int samples_checked = 0;

    always #25 clk = ~clk;

    pifeb_periph_model periph (.clk(clk), .sys_rst(sys_rst), .fire(fire),
        .adc_done_evt(ev_adc), .timer1_overflow_evt(ev_tmr), .osc_fail_evt(ev_osc),
        .nv_write_done_evt(ev_nv), .low_voltage_evt(ev_lvd), .pwm_period_match_evt(ev_pwm));

    pifeb_bank DUT (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .adc_done_evt(ev_adc),
        .rx_buffer_full(rx_buffer_full), .tx_buffer_empty(tx_buffer_empty),
        .comparator_out(comparator_out), .timer1_overflow_evt(ev_tmr),
        .osc_fail_evt(ev_osc), .nv_write_done_evt(ev_nv), .low_voltage_evt(ev_lvd),
        .pwm_period_match_evt(ev_pwm), .pwm_postscale(pwm_postscale),
        .priority_1(priority_1), .priority_2(priority_2), .priority_3(priority_3),
        .periph_irq_req(periph_irq_req), .irq_high_req(irq_high_req),
        .irq_low_req(irq_low_req));

    // Reference model; software write applied first so a same-edge event wins
    always @(posedge clk) begin
        if (sys_rst) begin
            {m_f1, m_f2, m_f3, m_e1, m_e2, m_e3, m_ctl} = '0;
            pcnt = 0;
            cmp_prev = comparator_out;
        end else begin
            if (write && !waitrequest && byteenable[0]) begin
                case (address)
                    PIFEB_OFS_FLAGS_1: m_f1 = writedata[7:0] & PIFEB_RW_FLAGS_1;
                    PIFEB_OFS_FLAGS_2: m_f2 = writedata[7:0] & PIFEB_MASK_2;
                    PIFEB_OFS_FLAGS_3: m_f3 = writedata[7:0] & PIFEB_MASK_3;
                    PIFEB_OFS_ENABLES_1: m_e1 = writedata[7:0] & PIFEB_MASK_1;
                    PIFEB_OFS_ENABLES_2: m_e2 = writedata[7:0] & PIFEB_MASK_2;
                    PIFEB_OFS_ENABLES_3: m_e3 = writedata[7:0] & PIFEB_MASK_3;
                    PIFEB_OFS_CORE_CTRL: m_ctl = writedata[7:0] & PIFEB_MASK_CTRL;
                    default: ;
                endcase
            end
            m_f1[PIFEB_BIT_ADC] |= ev_adc;
            m_f1[PIFEB_BIT_TMR1] |= ev_tmr;
            m_f1[3:1] |= comparator_out ^ cmp_prev;
            cmp_prev = comparator_out;
            m_f2[PIFEB_BIT_OSCF] |= ev_osc;
            m_f2[PIFEB_BIT_NVW] |= ev_nv;
            m_f2[PIFEB_BIT_LVD] |= ev_lvd;
            if (ev_pwm) begin
                if (pcnt >= int'(pwm_postscale)) begin
                    m_f3[PIFEB_BIT_PWM] = 1'b1;
                    pcnt = 0;
                end else begin
                    pcnt++;
                end
            end
        end
    end

    function automatic logic [7:0] f1_now();
        return m_f1 | {2'b00, rx_buffer_full, tx_buffer_empty, 4'h0};
    endfunction : f1_now

    function automatic logic [31:0] exp_read(input logic [4:0] a);
        case (a)
            PIFEB_OFS_FLAGS_1: return {24'h0, f1_now()};
            PIFEB_OFS_FLAGS_2: return {24'h0, m_f2};
            PIFEB_OFS_FLAGS_3: return {24'h0, m_f3};
            PIFEB_OFS_ENABLES_1: return {24'h0, m_e1};
            PIFEB_OFS_ENABLES_2: return {24'h0, m_e2};
            PIFEB_OFS_ENABLES_3: return {24'h0, m_e3};
            PIFEB_OFS_CORE_CTRL: return {24'h0, m_ctl};
            default: return 32'h0;
        endcase
    endfunction : exp_read

    function automatic logic [31:0] exp_irq();
        logic [7:0] x1, x2, x3;
        logic any, hi, lo, global_irq_enable, peripheral_global_enable;
        x1 = f1_now() & m_e1;
        x2 = m_f2 & m_e2;
        x3 = m_f3 & m_e3;
        any = |{x1, x2, x3};
        hi = |{x1 & priority_1, x2 & priority_2, x3 & priority_3};
        lo = |{x1 & ~priority_1, x2 & ~priority_2, x3 & ~priority_3};
        global_irq_enable = m_ctl[PIFEB_BIT_GIE];
        peripheral_global_enable = m_ctl[PIFEB_BIT_PERIPHERAL_GLOBAL_ENABLE];
        if (m_ctl[PIFEB_BIT_PRIORITY_LEVELS_ENABLE]) return {29'h0, any, global_irq_enable & hi, global_irq_enable & peripheral_global_enable & lo};
        return {29'h0, any, global_irq_enable & peripheral_global_enable & any, 1'b0};
    endfunction : exp_irq

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t ns: got %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        if (failures == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    // Always followed by a read, so write never rises again in the step it falls
    // ev pulses the sources for one clock so their events meet the landing write
    task automatic bus_write(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
                             input logic [5:0] ev);
        int n;
        n = 0;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        write <= 1'b1;
        fire <= ev;
        do begin
            @(posedge clk);
            n++;
            fire <= 6'h00;
        end while (waitrequest !== 1'b0 && n < 20);
        write <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        read <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        d = readdata;
        read <= 1'b0;
        @(posedge clk);
    endtask : bus_read

    initial begin
        #(20000 * 50);
        failures++;
        test_done();
    end

    initial begin
        logic [31:0] rd;
        void'($urandom(65));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            bus_read(5'(k * 4), rd);
            check(rd, 32'h0);
        end
        // Clear of the first flag register meets adc and timer events: sets win
        bus_write(PIFEB_OFS_FLAGS_1, 8'h00, 4'h1, 6'h3F);
        bus_read(PIFEB_OFS_FLAGS_1, rd);
        check(rd, 32'h00000041);
        // First pass fires every source with all enables off
        for (int i = 0; i < 60; i++) begin
            fire <= (i == 0) ? 6'h3F : 6'($urandom);
            rx_buffer_full <= 1'($urandom);
            tx_buffer_empty <= 1'($urandom);
            comparator_out <= 3'($urandom);
            pwm_postscale <= 4'($urandom_range(0, 3));
            priority_1 <= 8'($urandom);
            priority_2 <= 8'($urandom);
            priority_3 <= 8'($urandom);
            @(posedge clk);
            fire <= 6'h00;
            repeat (4) @(posedge clk);
            if (i > 0) bus_write(5'($urandom_range(0, 7) * 4), 8'($urandom), 4'($urandom),
                                 6'($urandom));
            for (int k = 0; k < 8; k++) begin
                bus_read(5'(k * 4), rd);
                check(rd, exp_read(5'(k * 4)));
            end
            check({29'h0, periph_irq_req, irq_high_req, irq_low_req}, exp_irq());
        end
        test_done();
    end
endmodule : tb

`default_nettype wire
